// ==== complementary_waveform_deadband_tb.sv ====
`timescale 1ns/1ps
module complementary_waveform_deadband_tb;
  logic        clock_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, sys_tick_i = 1, hf_tick_i = 1;
  logic        fault_input_n_i = 1, shoot;
  logic [2:0]  addr_i = 3'h0;
  logic [7:0]  wdata_i = 8'h00, rdata_o, q;
  logic [3:0]  src = 4'h0;
  logic        first_pwm_output_i, second_pwm_output_i, oscillator_output_i, logic_cell_output_i;
  logic        output_a_o, output_a_oe_n_o, output_b_o, output_b_oe_n_o;
  int          fail_count = 0, tests_run = 0, cyc = 0, g;
  // Rows: address, written value, value read back
  logic [23:0] rrow [7] = '{24'h00_fff9, 24'h01_fff3, 24'h02_7f43, 24'h03_ff3f, 24'h04_ff3f,
                            24'h05_ff00, 24'h07_ff00};
  // Rows: source, rising count, falling count
  int          drow [4][3] = '{'{0, 3, 5}, '{1, 0, 1}, '{2, 7, 0}, '{3, 1, 63}};
  assign {logic_cell_output_i, oscillator_output_i, second_pwm_output_i, first_pwm_output_i} = src;
  cwg_top dut_u (
    .clock_i             (clock_i),
    .rst_n_i             (rst_n_i),
    .addr_i              (addr_i),
    .wdata_i             (wdata_i),
    .wr_i                (wr_i),
    .rd_i                (rd_i),
    .rdata_o             (rdata_o),
    .sys_tick_i          (sys_tick_i),
    .hf_tick_i           (hf_tick_i),
    .first_pwm_output_i  (first_pwm_output_i),
    .second_pwm_output_i (second_pwm_output_i),
    .oscillator_output_i (oscillator_output_i),
    .logic_cell_output_i (logic_cell_output_i),
    .fault_input_n_i     (fault_input_n_i),
    .output_a_o          (output_a_o),
    .output_a_oe_n_o     (output_a_oe_n_o),
    .output_b_o          (output_b_o),
    .output_b_oe_n_o     (output_b_oe_n_o)
  );
  cwg_gate_drv drv_u (.a_i(output_a_o), .a_oe_n_i(output_a_oe_n_o), .b_i(output_b_o),
                      .b_oe_n_i(output_b_oe_n_o), .a_on_o(), .b_on_o(), .shoot_o(shoot));
  always #5 clock_i = ~clock_i;
  // Hang guard, well above the expected run
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop;
    end
  end
  task report_and_stop;
    if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [7:0] e, input logic [7:0] r);
    tests_run++;
    if (r !== e) begin
      fail_count++;
      $display("unexpected at %0t: exp %h got %h", $time, e, r);
    end
  endtask
  // One strobe cycle, one idle cycle; read data is taken in the idle cycle
  task acc(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] r);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    @(posedge clock_i);
    r = rdata_o;
  endtask
  task rdc(input logic [2:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00, q);
    chk(e, q);
  endtask
  task pin(input logic [7:0] e, input logic [7:0] m);
    repeat (8) @(posedge clock_i);
    chk(e, m & {4'h0, output_a_o, output_a_oe_n_o, output_b_o, output_b_oe_n_o});
  endtask
  // Off side must drop first; then count cycles until the on side starts
  task automatic gap(input logic up, input int n);
    int t;
    t = 0;
    g = 0;
    while ((up ? output_b_o : output_a_o) !== 1'b0 && t < 20) begin
      @(posedge clock_i);
      t++;
    end
    while ((up ? output_a_o : output_b_o) !== 1'b1 && g < 99) begin
      @(posedge clock_i);
      g++;
      if (shoot) t = 20;
    end
    tests_run++;
    if (t == 20 || (g != n && g != n + 1)) begin
      fail_count++;
      $display("unexpected gap at %0t: exp %h got %h", $time, n, g);
    end
  endtask
  initial begin
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    for (int a = 0; a < 5; a++) rdc(3'(a), 8'h00);
    for (int i = 0; i < 7; i++) begin
      acc(1'b1, rrow[i][18:16], rrow[i][15:8], q);
      rdc(rrow[i][18:16], rrow[i][7:0]);
    end
    acc(1'b1, 3'h2, 8'h00, q);
    acc(1'b1, 3'h0, 8'he0, q);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 3'h1, {6'h00, drow[i][0][1:0]}, q);
      acc(1'b1, 3'h3, 8'(drow[i][1]), q);
      acc(1'b1, 3'h4, 8'(drow[i][2]), q);
      repeat (80) @(posedge clock_i);
      src <= 4'h1 << drow[i][0];
      gap(1'b1, drow[i][1]);
      src <= 4'h0;
      gap(1'b0, drow[i][2]);
    end
    // Fault: B forced high, A released, status held by the level
    acc(1'b1, 3'h1, 8'hd1, q);
    acc(1'b1, 3'h2, 8'h01, q);
    fault_input_n_i <= 1'b0;
    pin(8'h06, 8'h07);
    rdc(3'h2, 8'h81);
    acc(1'b1, 3'h2, 8'h01, q);
    rdc(3'h2, 8'h81);
    fault_input_n_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    acc(1'b1, 3'h2, 8'h01, q);
    rdc(3'h2, 8'h01);
    src <= 4'h2;
    gap(1'b1, 1);
    // Logic cell shutdown with automatic restart
    acc(1'b1, 3'h1, 8'h21, q);
    acc(1'b1, 3'h2, 8'h42, q);
    src <= 4'ha;
    pin(8'h00, 8'h0c);
    rdc(3'h2, 8'hc2);
    src <= 4'h2;
    repeat (8) @(posedge clock_i);
    rdc(3'h2, 8'h42);
    src <= 4'h0;
    repeat (80) @(posedge clock_i);
    src <= 4'h2;
    gap(1'b1, 1);
    acc(1'b1, 3'h0, 8'hf8, q);
    pin(8'h02, 8'h0f);
    // No ticks on the selected clock: falling dead band never ends
    acc(1'b1, 3'h4, 8'h01, q);
    hf_tick_i <= 1'b0;
    acc(1'b1, 3'h0, 8'he1, q);
    src <= 4'h0;
    pin(8'h00, 8'h0a);
    hf_tick_i <= 1'b1;
    pin(8'h02, 8'h0a);
    acc(1'b1, 3'h0, 8'hc0, q);
    pin(8'h04, 8'h05);
    acc(1'b1, 3'h0, 8'h60, q);
    pin(8'h05, 8'h05);
    // Mid-run reset while driving: registers clear, pins released
    acc(1'b1, 3'h0, 8'he0, q);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rdc(3'h0, 8'h00);
    rdc(3'h2, 8'h00);
    pin(8'h05, 8'h05);
    report_and_stop;
  end
endmodule // complementary_waveform_deadband_tb

// ==== cwg_deadband.sv ====
`timescale 1ns/1ps
// One dead-band delay: output rises DB+1 ticks after input rises (DB zero bypasses), falls at once
module cwg_deadband
  import cwg_pkg::*;
(
  // Clock and reset
  input  wire logic    clock_i,
  input  wire logic    rst_n_i,
  // Control
  input  wire logic    tick_i,
  input  wire logic    in_i,
  input  wire cwg_db_t count_i,
  // Result
  output logic         out_o
);
  cwg_db_t cnt_reg;
  cwg_db_t cnt_next;
  logic    out_reg;
  logic    out_next;

  // Count ticks since input went high; zero count bypasses
  always_comb begin
    cnt_next = cnt_reg;
    out_next = out_reg;
    if (!in_i) begin
      cnt_next = '0;
      out_next = 1'b0;
    end else if (count_i == '0) begin
      out_next = 1'b1; // [R14]
    end else if (tick_i && !out_reg) begin
      if (cnt_reg == count_i) begin
        out_next = 1'b1; // [R13]
      end else begin
        cnt_next = cnt_reg + 6'h01;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign out_o = out_reg;
endmodule // cwg_deadband

// ==== cwg_gate_drv.sv ====
`timescale 1ns/1ps
// Two gate drivers; a released pin falls to the driver pull-down
module cwg_gate_drv (
  // Pins from the generator
  input  wire logic a_i,
  input  wire logic a_oe_n_i,
  input  wire logic b_i,
  input  wire logic b_oe_n_i,
  // Switch states
  output logic      a_on_o,
  output logic      b_on_o,
  output logic      shoot_o
);
  // Undriven pin means switch off, never a stale level
  assign a_on_o  = !a_oe_n_i && a_i;
  assign b_on_o  = !b_oe_n_i && b_i;
  // Both switches on is shoot-through
  assign shoot_o = a_on_o && b_on_o;
endmodule // cwg_gate_drv

// ==== cwg_pkg.sv ====
package cwg_pkg;
  typedef enum logic [1:0] {
    CWG_SRC_PWM1 = 2'h0,
    CWG_SRC_PWM2 = 2'h1,
    CWG_SRC_OSC  = 2'h2,
    CWG_SRC_LC   = 2'h3
  } cwg_src_e;
  typedef logic [5:0] cwg_db_t;
endpackage

// ==== cwg_regs.svh ====
`ifndef CWG_REGS_SVH
`define CWG_REGS_SVH
// Function
// [R1] Enable bit runs generator; resets zero
// [R2] Output reaches pin only when enabled
// [R3] Polarity bit inverts each output
// [R4] Clock select: HF oscillator or system
// [R5] Output B shutdown level encoding
// [R6] Output A shutdown level encoding
// [R7] Input source select, resets to first PWM
// [R8] Shutdown status overrides output enables
// [R9] Status bit writable, hardware sets/clears
// [R10] Auto-restart enable selects restart mode
// [R11] Logic cell high forces shutdown when enabled
// [R12] Fault pin low forces shutdown when enabled
// [R13] Rising dead band N to N+1 counts
// [R14] Falling dead band zero means bypass
// [R15] Unimplemented bits read zero
// [R16] Rise: B off now, A after delay
// [R17] Fall: A off now, B after delay
// [R18] Shutdown inputs level sensitive, block clearing
// [R19] Resume on first rising edge after clear
// [R20] Synchronise inputs into generator clock domain

// Register offsets
`define CWG_OFS_CON0 3'h0
`define CWG_OFS_CON1 3'h1
`define CWG_OFS_CON2 3'h2
`define CWG_OFS_DBR  3'h3
`define CWG_OFS_DBF  3'h4

// Field positions
`define CWG_EN_BIT    7
`define CWG_OEB_BIT   6
`define CWG_OEA_BIT   5
`define CWG_POLB_BIT  4
`define CWG_POLA_BIT  3
`define CWG_CS_BIT    0
`define CWG_ASE_BIT   7
`define CWG_ARS_BIT   6
`define CWG_SLC_BIT   1
`define CWG_SFLT_BIT  0

// Writable masks and reset values
`define CWG_CON0_MASK 8'hf9
`define CWG_CON1_MASK 8'hf3
`define CWG_CON2_MASK 8'hc3
`define CWG_DB_MASK   8'h3f
`define CWG_RST_VAL   8'h00

// Shutdown level codes
`define CWG_SD_HIGH   2'h3
`define CWG_SD_LOW    2'h2
`define CWG_SD_TRI    2'h1
`define CWG_SD_INACT  2'h0
`endif

// ==== cwg_top.sv ====
`timescale 1ns/1ps
`include "cwg_regs.svh"
// Complementary waveform generator with dead band and auto-shutdown
module cwg_top
  import cwg_pkg::*;
(
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  // Register port
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Generator clock enables
  input  wire logic       sys_tick_i,
  input  wire logic       hf_tick_i,
  // Waveform and shutdown sources (asynchronous)
  input  wire logic       first_pwm_output_i,
  input  wire logic       second_pwm_output_i,
  input  wire logic       oscillator_output_i,
  input  wire logic       logic_cell_output_i,
  input  wire logic       fault_input_n_i,
  // Output pins
  output logic            output_a_o,
  output logic            output_a_oe_n_o,
  output logic            output_b_o,
  output logic            output_b_oe_n_o
);
  // Reset release synchroniser
  logic rst_s1_reg;
  logic rst_s2_reg;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire rst_n = rst_s2_reg;

  // Two-stage synchronisers for every async input
  logic [4:0] async_in;
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  assign async_in = {fault_input_n_i, logic_cell_output_i, oscillator_output_i,
                     second_pwm_output_i, first_pwm_output_i};
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 5'h10; // Fault pin idles high
      sync2_reg <= 5'h10;
    end else begin
      sync1_reg <= async_in; // [R20]
      sync2_reg <= sync1_reg;
    end
  end

  // Registers and their next values
  logic [7:0] con0_reg;
  logic [7:0] con0_next;
  logic [7:0] con1_reg;
  logic [7:0] con1_next;
  logic [7:0] con2_reg;
  logic [7:0] con2_next;
  logic [7:0] dbr_reg;
  logic [7:0] dbr_next;
  logic [7:0] dbf_reg;
  logic [7:0] dbf_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Decoded fields
  wire       mod_en     = con0_reg[`CWG_EN_BIT];
  wire       out_b_en   = con0_reg[`CWG_OEB_BIT];
  wire       out_a_en   = con0_reg[`CWG_OEA_BIT];
  wire       out_b_inv  = con0_reg[`CWG_POLB_BIT];
  wire       out_a_inv  = con0_reg[`CWG_POLA_BIT];
  wire       clk_sel    = con0_reg[`CWG_CS_BIT];
  wire [1:0] out_b_sdl  = con1_reg[7:6];
  wire [1:0] out_a_sdl  = con1_reg[5:4];
  wire [1:0] src_sel    = con1_reg[1:0];
  wire       sd_status  = con2_reg[`CWG_ASE_BIT];
  wire       auto_rst   = con2_reg[`CWG_ARS_BIT];
  wire       lc_sd_en   = con2_reg[`CWG_SLC_BIT];
  wire       flt_sd_en  = con2_reg[`CWG_SFLT_BIT];

  // Shutdown request is a level, not an edge
  logic sd_req;
  assign sd_req = (lc_sd_en && sync2_reg[3])      // [R11]
                | (flt_sd_en && !sync2_reg[4]); // [R12] [R18]

  // Selected input
  logic src_sel_in;
  always_comb begin
    case (cwg_src_e'(src_sel)) // [R7]
      CWG_SRC_PWM1: src_sel_in = sync2_reg[0];
      CWG_SRC_PWM2: src_sel_in = sync2_reg[1];
      CWG_SRC_OSC:  src_sel_in = sync2_reg[2];
      CWG_SRC_LC:   src_sel_in = sync2_reg[3];
      default:      src_sel_in = sync2_reg[0];
    endcase
  end

  // Edge detect and restart arming
  logic src_prev_reg;
  logic src_prev_next;
  logic run_reg;
  logic run_next;
  // History resets low; harmless, the generator is off until enabled
  wire  rise = src_sel_in && !src_prev_reg;

  // Register writes; hardware set of status wins over software clear
  always_comb begin
    con0_next = con0_reg;
    con1_next = con1_reg;
    con2_next = con2_reg;
    dbr_next  = dbr_reg;
    dbf_next  = dbf_reg;
    if (wr_i) begin
      case (addr_i)
        `CWG_OFS_CON0: con0_next = wdata_i & `CWG_CON0_MASK; // [R15]
        `CWG_OFS_CON1: con1_next = wdata_i & `CWG_CON1_MASK;
        `CWG_OFS_CON2: con2_next = wdata_i & `CWG_CON2_MASK; // [R9]
        `CWG_OFS_DBR:  dbr_next  = wdata_i & `CWG_DB_MASK;
        `CWG_OFS_DBF:  dbf_next  = wdata_i & `CWG_DB_MASK;
        default: ;
      endcase
    end
    if (sd_req) begin
      con2_next[`CWG_ASE_BIT] = 1'b1; // [R9] [R18]
    end else if (auto_rst && sd_status) begin
      con2_next[`CWG_ASE_BIT] = 1'b0; // [R10]
    end
  end

  // Read mux, data valid the cycle after the strobe
  always_comb begin
    rdata_next = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `CWG_OFS_CON0: rdata_next = con0_reg;
        `CWG_OFS_CON1: rdata_next = con1_reg;
        `CWG_OFS_CON2: rdata_next = con2_reg;
        `CWG_OFS_DBR:  rdata_next = dbr_reg;
        `CWG_OFS_DBF:  rdata_next = dbf_reg;
        default:       rdata_next = 8'h00;
      endcase
    end
  end

  // Restart waits for a rising edge after status clears
  always_comb begin
    src_prev_next = src_sel_in;
    run_next      = run_reg;
    if (!mod_en || sd_status) begin
      run_next = 1'b0;
    end else if (rise) begin
      run_next = 1'b1; // [R19]
    end
  end

  // Control registers
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      con0_reg <= `CWG_RST_VAL; // [R1]
      con1_reg <= `CWG_RST_VAL;
      con2_reg <= `CWG_RST_VAL;
      dbr_reg  <= `CWG_RST_VAL;
      dbf_reg  <= `CWG_RST_VAL;
    end else begin
      con0_reg <= con0_next;
      con1_reg <= con1_next;
      con2_reg <= con2_next;
      dbr_reg  <= dbr_next;
      dbf_reg  <= dbf_next;
    end
  end

  // Read data register; zero outside the cycle after a read strobe
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign rdata_o = rdata_reg;

  // Edge history and run flag
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      src_prev_reg <= 1'b0;
      run_reg      <= 1'b0;
    end else begin
      src_prev_reg <= src_prev_next;
      run_reg      <= run_next;
    end
  end

  // Generator tick from chosen clock source
  logic gen_tick;
  assign gen_tick = clk_sel ? hf_tick_i : sys_tick_i; // [R4]

  // Drive waveform held low until running; during shutdown it goes low too
  logic wave;
  assign wave = mod_en && run_reg && src_sel_in; // [R1]
  logic wave_n;
  assign wave_n = mod_en && !(run_reg && src_sel_in);

  logic a_raw;
  logic b_raw;
  // A follows input after rising delay, B after falling delay
  cwg_deadband u_db_rise (
    .clock_i (clock_i),
    .rst_n_i (rst_n),
    .tick_i  (gen_tick),
    .in_i    (wave),
    .count_i (dbr_reg[5:0]),
    .out_o   (a_raw)
  ); // [R16]
  cwg_deadband u_db_fall (
    .clock_i (clock_i),
    .rst_n_i (rst_n),
    .tick_i  (gen_tick),
    .in_i    (wave_n),
    .count_i (dbf_reg[5:0]),
    .out_o   (b_raw)
  ); // [R17]

  // Output stage: polarity, shutdown overrides, enables
  logic a_next;
  logic a_oe_n_next;
  logic b_next;
  logic b_oe_n_next;
  logic a_reg;
  logic a_oe_n_reg;
  logic b_reg;
  logic b_oe_n_reg;
  always_comb begin
    a_next      = a_raw ^ out_a_inv; // [R3]
    b_next      = b_raw ^ out_b_inv;
    a_oe_n_next = !(mod_en && out_a_en); // [R2]
    b_oe_n_next = !(mod_en && out_b_en);
    if (mod_en && sd_status) begin
      // Overrides ignore polarity except the inactive code
      case (out_a_sdl) // [R6] [R8]
        `CWG_SD_HIGH: begin
          a_next      = 1'b1;
          a_oe_n_next = 1'b0;
        end
        `CWG_SD_LOW: begin
          a_next      = 1'b0;
          a_oe_n_next = 1'b0;
        end
        `CWG_SD_TRI: begin
          a_next      = 1'b0; // Parked low, so no stale level when re-driven
          a_oe_n_next = 1'b1;
        end
        default: begin
          a_next      = a_raw ^ out_a_inv;
          a_oe_n_next = 1'b0;
        end
      endcase
      case (out_b_sdl) // [R5] [R8]
        `CWG_SD_HIGH: begin
          b_next      = 1'b1;
          b_oe_n_next = 1'b0;
        end
        `CWG_SD_LOW: begin
          b_next      = 1'b0;
          b_oe_n_next = 1'b0;
        end
        `CWG_SD_TRI: begin
          b_next      = 1'b0; // Parked low, so no stale level when re-driven
          b_oe_n_next = 1'b1;
        end
        default: begin
          b_next      = b_raw ^ out_b_inv;
          b_oe_n_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      a_reg      <= 1'b0;
      b_reg      <= 1'b0;
      a_oe_n_reg <= 1'b1;
      b_oe_n_reg <= 1'b1;
    end else begin
      a_reg      <= a_next;
      b_reg      <= b_next;
      a_oe_n_reg <= a_oe_n_next;
      b_oe_n_reg <= b_oe_n_next;
    end
  end
  assign output_a_o      = a_reg;
  assign output_b_o      = b_reg;
  assign output_a_oe_n_o = a_oe_n_reg;
  assign output_b_oe_n_o = b_oe_n_reg;
endmodule // cwg_top

// ==== cwg_top_sva.sv ====
`timescale 1ns/1ps
module cwg_top_sva (
  // Clock and reset
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  // Register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  // Generator ticks
  input wire logic       sys_tick_i,
  input wire logic       hf_tick_i,
  // Waveform and shutdown sources
  input wire logic       first_pwm_output_i,
  input wire logic       second_pwm_output_i,
  input wire logic       oscillator_output_i,
  input wire logic       logic_cell_output_i,
  input wire logic       fault_input_n_i,
  // Output pins
  input wire logic       output_a_o,
  input wire logic       output_a_oe_n_o,
  input wire logic       output_b_o,
  input wire logic       output_b_oe_n_o
);
  logic [7:0] c0_reg, c1_reg, c2_reg;
  logic       flt, lc;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // Shadow of software writes; hardware status moves are not mirrored
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c0_reg <= 8'h00;
      c1_reg <= 8'h00;
      c2_reg <= 8'h00;
    end else if (wr_i) begin
      if (addr_i == 3'h0) c0_reg <= wdata_i;
      if (addr_i == 3'h1) c1_reg <= wdata_i;
      if (addr_i == 3'h2) c2_reg <= wdata_i;
    end
  end
  // Live shutdown sources while enabled
  assign flt = c0_reg[7] && c2_reg[0] && !fault_input_n_i;
  assign lc  = c0_reg[7] && c2_reg[1] && logic_cell_output_i;
  property p_resv;
    rd_i && addr_i == 3'h0 |=> rdata_o[2:1] == 2'b00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_unmap;
    rd_i && addr_i > 3'h4 |=> rdata_o == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_dbtop;
    rd_i && addr_i inside {3'h3, 3'h4} |=> rdata_o[7:6] == 2'b00;
  endproperty
  a_dbtop: assert property (p_dbtop) else $error("dead band top bits set");
  property p_off;
    wr_i && addr_i == 3'h0 && !wdata_i[7] |-> ##[1:4] (output_a_oe_n_o && output_b_oe_n_o);
  endproperty
  a_off: assert property (p_off) else $error("pins driven while disabled");
  property p_oea;
    wr_i && addr_i == 3'h0 && !wdata_i[5] |-> ##[1:4] output_a_oe_n_o;
  endproperty
  a_oea: assert property (p_oea) else $error("output a driven while off");
  property p_sdhi;
    flt && c1_reg[7:6] == 2'h3 |-> ##[1:8] (output_b_o && !output_b_oe_n_o);
  endproperty
  a_sdhi: assert property (p_sdhi) else $error("b not forced high");
  property p_sdlo;
    lc && c1_reg[5:4] == 2'h2 |-> ##[1:8] (!output_a_o && !output_a_oe_n_o);
  endproperty
  a_sdlo: assert property (p_sdlo) else $error("a not forced low");
  property p_sdtri;
    flt && c1_reg[5:4] == 2'h1 |-> ##[1:8] output_a_oe_n_o;
  endproperty
  a_sdtri: assert property (p_sdtri) else $error("a not released");
  // Main scenarios reached
  c_flt: cover property (flt);
  c_lc: cover property (lc);
  c_rd2: cover property (rd_i && addr_i == 3'h2);
endmodule // cwg_top_sva
bind cwg_top cwg_top_sva chk_u (
  .clock_i             (clock_i),
  .rst_n_i             (rst_n_i),
  .addr_i              (addr_i),
  .wdata_i             (wdata_i),
  .wr_i                (wr_i),
  .rd_i                (rd_i),
  .rdata_o             (rdata_o),
  .sys_tick_i          (sys_tick_i),
  .hf_tick_i           (hf_tick_i),
  .first_pwm_output_i  (first_pwm_output_i),
  .second_pwm_output_i (second_pwm_output_i),
  .oscillator_output_i (oscillator_output_i),
  .logic_cell_output_i (logic_cell_output_i),
  .fault_input_n_i     (fault_input_n_i),
  .output_a_o          (output_a_o),
  .output_a_oe_n_o     (output_a_oe_n_o),
  .output_b_o          (output_b_o),
  .output_b_oe_n_o     (output_b_oe_n_o)
);
